// ### rtl/hub_boot_config_sequencer.sv
// Boot-stage sequencer of the hub: standby, flash probe, ROM load, straps, sideband config, OTP merge, attach.
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/100ps
module hub_boot_config_sequencer
  import hbc_pkg::*;
#(
  parameter logic [15:0] PLL_LOCK = PLL_LOCK_CNT,
  parameter logic [1:0] FLASH_WIDTH = 2'h1,
  parameter logic FLASH_MODE3 = 1'b0
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // Straps and board sense.
  input wire logic [2:0] bootSelectStraps,
  input wire logic [NPORT-1:0] portDisablePlusStraps,
  input wire logic [NPORT-1:0] portDisableMinusStraps,
  input wire logic nonremovableStrap,
  input wire logic chargingEnableStrap,
  input wire logic pllLocked,
  input wire logic sdaPullup,
  input wire logic sclPullup,
  // Flash byte read port.
  input wire logic flashAck,
  input wire logic [7:0] flashByte,
  // Sideband slave writes and commands.
  input wire logic sbWrite,
  input wire logic [AW-1:0] sbAddr,
  input wire logic [DW-1:0] sbData,
  input wire logic sbCmdValid,
  input wire logic [15:0] sbCmd,
  input wire logic legacyMode,
  // ROM defaults and OTP contents.
  input wire logic [DW-1:0] romData,
  input wire logic [DW-1:0] otpData,
  input wire logic otpValid,
  // Upstream host events.
  input wire logic hostStarted,
  input wire logic softDisconnect,
  // Register read port.
  input wire logic [AW-1:0] regAddr,
  input wire logic regRd,
  output logic [DW-1:0] regRdData,
  // Flash request.
  output logic flashReq,
  output logic [23:0] flashAddr,
  output logic [1:0] flashWidth,
  output logic flashMode3,
  output logic execFromFlash,
  // Strap results.
  output logic [NPORT-1:0] portDisP,
  output logic [NPORT-1:0] portDisM,
  output logic nonRemovable,
  output logic chargeEn,
  // ROM and OTP walk.
  output logic [AW-1:0] cfgIdx,
  output logic otpRd,
  // Hub controls.
  output logic sidebandSlave,
  output logic keepSideband,
  output logic usb2AttachBit,
  output logic superspeedHubEnableBit,
  output logic portsEnable,
  output logic dataPinsDrive,
  output logic pllRun,
  output logic [3:0] bootStage
);

  hbc_state_s rState;
  hbc_state_s nxtState;
  logic [DW-1:0] cfgMem [NREG];
  logic [DW-1:0] rdData_ff;
  logic [1:0] flashWidth_ff;
  logic flashMode3_ff;
  logic [DW-1:0] nxt_rdData;
  logic [7:0] sigExp;
  logic endCfg;

  always_comb begin
    sigExp = SIG_WORD[8'(31 - 8 * 32'(rState.sigIdx)) -: 8];
  end

  // Legacy mode ends on a write to the final register, otherwise on an attach command.
  always_comb begin
    endCfg = legacyMode ? (sbWrite && sbAddr == LEGACY_END_REG)
                        : (sbCmdValid && (sbCmd == ATTACH_CMD || sbCmd == ATTACH_KEEP_SIDEBAND_CMD));
  end

  always_comb begin
    nxtState = rState;
    nxtState.cfgWe = 1'b0;
    nxtState.otpRd = 1'b0;
    nxtState.flashReq = 1'b0;
    nxtState.romLoad = 1'b0;
    case (rState.stage)
      ST_STANDBY: begin
        nxtState.stage = ST_FLASH_PROBE;
        nxtState.pllRun = 1'b1;
        nxtState.cnt = '0;
      end
      ST_FLASH_PROBE: begin
        if (rState.cnt < PLL_LOCK || !pllLocked) begin
          nxtState.cnt = rState.cnt + 16'h0001;
          nxtState.sigIdx = 2'h0;
          nxtState.sigOk = 1'b1;
        end else if (bootSelectStraps != BOOT_SEL_FLASH) begin
          nxtState.stage = ST_ROM_LOAD;
        end else if (!flashAck) begin
          nxtState.flashReq = 1'b1;
          nxtState.flashAddr = SIG_ADDR + 24'(rState.sigIdx);
        end else begin
          nxtState.sigOk = rState.sigOk && (flashByte == sigExp);
          nxtState.sigIdx = rState.sigIdx + 2'h1;
          if (rState.sigIdx == SIG_LEN_M1) begin
            if (rState.sigOk && flashByte == sigExp) begin
              nxtState.stage = ST_FLASH_EXEC;
              nxtState.execFlash = 1'b1;
              nxtState.flashAddr = EXEC_ADDR;
            end else begin
              nxtState.stage = ST_ROM_LOAD;
            end
            nxtState.idx = '0;
          end
        end
      end
      ST_FLASH_EXEC: begin
        nxtState.stage = ST_FLASH_EXEC;
      end
      ST_ROM_LOAD: begin
        nxtState.romLoad = 1'b1;
        nxtState.cfgWe = rState.romLoad;
        nxtState.cfgAddr = rState.idx - 8'h01;
        nxtState.cfgData = romData;
        nxtState.idx = rState.idx + 8'h01;
        if (rState.romLoad && rState.idx == 8'h00) begin
          nxtState.stage = ST_STRAP;
          nxtState.romLoad = 1'b0;
        end
      end
      ST_STRAP: begin
        nxtState.bootSel = bootSelectStraps;
        nxtState.portDisP = portDisablePlusStraps;
        nxtState.portDisM = portDisableMinusStraps;
        nxtState.nonRemovable = nonremovableStrap;
        nxtState.chargeEn = chargingEnableStrap;
        nxtState.idx = '0;
        nxtState.stage = (bootSelectStraps == BOOT_SEL_SMBUS) ? ST_PULLUP_PROBE : ST_OTP_MERGE;
      end
      ST_PULLUP_PROBE: begin
        if (sdaPullup && sclPullup) begin
          nxtState.sidebandSlave = 1'b1;
          nxtState.stage = ST_EXT_CFG;
        end else begin
          nxtState.stage = ST_OTP_MERGE;
        end
      end
      ST_EXT_CFG: begin
        nxtState.cfgWe = sbWrite && !(legacyMode && sbAddr == LEGACY_END_REG);
        nxtState.cfgAddr = sbAddr;
        nxtState.cfgData = sbData;
        if (endCfg) begin
          nxtState.keepSideband = !legacyMode && sbCmd == ATTACH_KEEP_SIDEBAND_CMD;
          nxtState.sidebandSlave = !legacyMode && sbCmd == ATTACH_KEEP_SIDEBAND_CMD;
          nxtState.stage = ST_OTP_MERGE;
          nxtState.idx = '0;
        end
      end
      ST_OTP_MERGE: begin
        nxtState.otpRd = 1'b1;
        nxtState.cfgWe = rState.otpRd && otpValid;
        nxtState.cfgAddr = rState.idx - 8'h01;
        nxtState.cfgData = otpData;
        nxtState.idx = rState.idx + 8'h01;
        if (rState.otpRd && rState.idx == 8'h00) begin
          nxtState.otpRd = 1'b0;
          nxtState.stage = ST_ATTACH;
        end
      end
      ST_ATTACH: begin
        nxtState.usb2Attach = !softDisconnect;
        nxtState.ssHubEnable = !softDisconnect;
        nxtState.portsEnable = 1'b1;
        nxtState.pinsDrive = 1'b1;
        if (hostStarted && !softDisconnect) begin
          nxtState.stage = ST_NORMAL;
        end
      end
      ST_NORMAL: begin
        if (softDisconnect) begin
          nxtState.stage = ST_ATTACH;
          nxtState.usb2Attach = 1'b0;
          nxtState.ssHubEnable = 1'b0;
        end
      end
      default: begin
        nxtState.stage = ST_STANDBY;
      end
    endcase
  end

  // Asynchronous reset clears every stage bit; the configuration register array is not reset and keeps its contents.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rState <= '0;
    end else begin
      rState <= nxtState;
    end
  end

  // Configuration register array; the later OTP write overrides the sideband one.
  always_ff @(posedge ref_clk) begin
    if (rState.cfgWe) begin
      cfgMem[rState.cfgAddr] <= rState.cfgData;
    end
  end

  always_comb begin
    nxt_rdData = rdData_ff;
    if (regRd) begin
      nxt_rdData = (rState.stage == ST_STANDBY) ? CFG_RST : cfgMem[regAddr];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdData_ff <= CFG_RST;
      flashWidth_ff <= 2'h0;
      flashMode3_ff <= 1'b0;
    end else begin
      rdData_ff <= nxt_rdData;
      flashWidth_ff <= FLASH_WIDTH;
      flashMode3_ff <= FLASH_MODE3;
    end
  end

  assign regRdData = rdData_ff;
  assign flashReq = rState.flashReq;
  assign flashAddr = rState.flashAddr;
  assign flashWidth = flashWidth_ff;
  assign flashMode3 = flashMode3_ff;
  assign execFromFlash = rState.execFlash;
  assign portDisP = rState.portDisP;
  assign portDisM = rState.portDisM;
  assign nonRemovable = rState.nonRemovable;
  assign chargeEn = rState.chargeEn;
  assign cfgIdx = rState.idx;
  assign otpRd = rState.otpRd;
  assign sidebandSlave = rState.sidebandSlave;
  assign keepSideband = rState.keepSideband;
  assign usb2AttachBit = rState.usb2Attach;
  assign superspeedHubEnableBit = rState.ssHubEnable;
  assign portsEnable = rState.portsEnable;
  assign dataPinsDrive = rState.pinsDrive;
  assign pllRun = rState.pllRun;
  assign bootStage = rState.stage;

endmodule // hub_boot_config_sequencer

// ### rtl/hbc_pkg.sv
// Package holding constants, stage encodings and state layout of the hub boot sequencer.
package hbc_pkg;

  // Flash signature probe.
  localparam logic [23:0] SIG_ADDR = 24'h3FFFA;
  localparam logic [23:0] EXEC_ADDR = 24'h00000;
  localparam logic [31:0] SIG_WORD = 32'h32444655;
  localparam logic [1:0] SIG_LEN_M1 = 2'h3;

  // Boot-select strap codes.
  localparam logic [2:0] BOOT_SEL_SMBUS = 3'h1;
  localparam logic [2:0] BOOT_SEL_FLASH = 3'h0;

  // Sideband termination codes.
  localparam logic [7:0] LEGACY_END_REG = 8'hFF;
  localparam logic [15:0] ATTACH_CMD = 16'hAA55;
  localparam logic [15:0] ATTACH_KEEP_SIDEBAND_CMD = 16'hAA56;

  // Widths and counts.
  localparam int NPORT = 6;
  localparam int AW = 8;
  localparam int DW = 8;
  localparam int NREG = 256;

  // Timing counts at 40 MHz.
  localparam int CLK_MHZ = 40;
  localparam int PLL_LOCK_US = 10;
  localparam int PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
  localparam logic [15:0] PLL_LOCK_CNT = 16'(PLL_LOCK_CYC);

  // Reset values.
  localparam logic [DW-1:0] CFG_RST = 8'h00;

  typedef enum logic [3:0] {
    ST_STANDBY = 4'h0,
    ST_FLASH_PROBE = 4'h1,
    ST_FLASH_EXEC = 4'h2,
    ST_ROM_LOAD = 4'h3,
    ST_STRAP = 4'h4,
    ST_PULLUP_PROBE = 4'h5,
    ST_EXT_CFG = 4'h6,
    ST_OTP_MERGE = 4'h7,
    ST_ATTACH = 4'h8,
    ST_NORMAL = 4'h9
  } hbc_stage_e;

  typedef struct packed {
    hbc_stage_e stage;
    logic [15:0] cnt;
    logic [1:0] sigIdx;
    logic sigOk;
    logic flashReq;
    logic [23:0] flashAddr;
    logic execFlash;
    logic [2:0] bootSel;
    logic [NPORT-1:0] portDisP;
    logic [NPORT-1:0] portDisM;
    logic nonRemovable;
    logic chargeEn;
    logic romLoad;
    logic [AW-1:0] idx;
    logic otpRd;
    logic cfgWe;
    logic [AW-1:0] cfgAddr;
    logic [DW-1:0] cfgData;
    logic sidebandSlave;
    logic keepSideband;
    logic usb2Attach;
    logic ssHubEnable;
    logic portsEnable;
    logic pinsDrive;
    logic pllRun;
  } hbc_state_s;

endpackage

// ### tb/hbc_seq_chk.sv
// Port assertions for the hub boot sequencer.
`timescale 1ns/100ps
module hbc_seq_chk
  import hbc_pkg::*;
(
  // Clock, reset and inputs.
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [2:0] bootSelectStraps,
  input wire logic sdaPullup,
  input wire logic sclPullup,
  input wire logic sbWrite,
  input wire logic sbCmdValid,
  input wire logic hostStarted,
  input wire logic softDisconnect,
  // Outputs.
  input wire logic flashReq,
  input wire logic [23:0] flashAddr,
  input wire logic execFromFlash,
  input wire logic usb2AttachBit,
  input wire logic portsEnable,
  input wire logic [3:0] bootStage
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  AST_STANDBY: assert property (disable iff (1'b0) !rstn |-> bootStage == 4'h0 && !portsEnable)
    else $error("standby");
  AST_PROBE: assert property (!$past(rstn) |=> bootStage == 4'h1)
    else $error("probe entry");
  AST_SIG_ADDR: assert property (flashReq |-> bootStage == 4'h1 && flashAddr inside {[SIG_ADDR:SIG_ADDR + 24'h3]})
    else $error("flash addr");
  AST_EXEC: assert property (bootStage == 4'h2 |-> execFromFlash && flashAddr == EXEC_ADDR)
    else $error("exec");
  AST_NO_FLASH: assert property (bootSelectStraps != BOOT_SEL_FLASH |-> !flashReq)
    else $error("flash skip");
  AST_STRAP: assert property ($past(bootStage) == 4'h4 && bootStage != 4'h4
    |-> bootStage == ((bootSelectStraps == BOOT_SEL_SMBUS) ? 4'h5 : 4'h7))
    else $error("strap exit");
  AST_PULLUP: assert property ($past(bootStage) == 4'h5 && bootStage != 4'h5
    |-> bootStage == ((sdaPullup && sclPullup) ? 4'h6 : 4'h7))
    else $error("pullup exit");
  AST_EXT_WAIT: assert property (bootStage == 4'h6 && !sbCmdValid && !sbWrite |=> bootStage == 4'h6)
    else $error("ext wait");
  AST_DISC: assert property (bootStage inside {4'h8, 4'h9} && softDisconnect |=> bootStage == 4'h8 && !usb2AttachBit)
    else $error("disconnect");
  AST_NORMAL: assert property (bootStage == 4'h8 && hostStarted && !softDisconnect
    |=> bootStage == 4'h9 && usb2AttachBit && portsEnable)
    else $error("normal");
endmodule // hbc_seq_chk
bind hub_boot_config_sequencer hbc_seq_chk hbc_seq_chk_i (.*);

// ### tb/hbc_far_model.sv
// Behavioural serial flash and sideband master.
`timescale 1ns/100ps
module hbc_far_model
  import hbc_pkg::*;
(
  // Clock and design side.
  input wire logic ref_clk,
  input wire logic flashReq,
  input wire logic [23:0] flashAddr,
  input wire logic [3:0] bootStage,
  // Scenario controls.
  input wire logic badSig,
  input wire logic [3:0] ackDly,
  input wire logic [1:0] endMode,
  // Answers.
  output logic flashAck,
  output logic [7:0] flashByte,
  output logic sbWrite,
  output logic [7:0] sbAddr,
  output logic [7:0] sbData,
  output logic sbCmdValid,
  output logic [15:0] sbCmd,
  output logic legacyMode
);
  logic [3:0] cnt;
  logic [7:0] t;
  logic [1:0] i;
  logic hit;
  logic fin;
  assign i = 2'(flashAddr - SIG_ADDR);
  assign hit = flashReq && !flashAck && cnt == ackDly;
  assign fin = t == 8'hC8;
  assign legacyMode = endMode == 2'h0;
  initial {flashAck, flashByte, sbWrite, sbAddr, sbData, sbCmdValid, sbCmd, cnt, t} = '0;
  always @(posedge ref_clk) begin
    flashAck <= hit;
    flashByte <= hit ? (badSig ? 8'h00 : SIG_WORD[8*(3-i) +: 8]) : ~flashByte;
    cnt <= (flashReq && !flashAck && !hit) ? cnt + 4'h1 : 4'h0;
    t <= (bootStage == 4'h6) ? t + 8'h01 : 8'h00;
    sbWrite <= t == 8'h02 || t == 8'h03 || (legacyMode && fin);
    sbAddr <= (t == 8'h02) ? 8'h10 : (t == 8'h03) ? 8'h20 : fin ? LEGACY_END_REG : ~sbAddr;
    sbData <= (t == 8'h02) ? 8'hC3 : (t == 8'h03) ? 8'h3C : ~sbData;
    sbCmdValid <= !legacyMode && fin;
    sbCmd <= fin ? ((endMode == 2'h2) ? ATTACH_KEEP_SIDEBAND_CMD : ATTACH_CMD) : ~sbCmd;
  end
endmodule // hbc_far_model

// ### tb/testbench.sv
// Self-checking bench for the hub boot sequencer.
`timescale 1ns/100ps
module testbench;
  import hbc_pkg::*;
  logic ref_clk = 1'b0, rstn = 1'b1, regRd = 1'b0, badSig = 1'b0, pllLocked = 1'b1;
  logic [2:0] bootSelectStraps = 3'h0;
  logic [NPORT-1:0] portDisablePlusStraps = 6'h2A, portDisableMinusStraps = 6'h15;
  logic nonremovableStrap = 1'b1, chargingEnableStrap = 1'b0, sdaPullup = 1'b0, sclPullup = 1'b0;
  logic hostStarted = 1'b0, softDisconnect = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [3:0] ackDly = 4'h0;
  logic [1:0] endMode = 2'h0;
  logic flashAck, sbWrite, sbCmdValid, legacyMode, otpValid, flashReq, flashMode3, execFromFlash;
  logic nonRemovable, chargeEn, otpRd, sidebandSlave, keepSideband, usb2AttachBit, superspeedHubEnableBit;
  logic portsEnable, dataPinsDrive, pllRun;
  logic [7:0] flashByte, sbAddr, sbData, romData, otpData, regRdData, cfgIdx;
  logic [15:0] sbCmd;
  logic [23:0] flashAddr;
  logic [1:0] flashWidth;
  logic [NPORT-1:0] portDisP, portDisM;
  logic [3:0] bootStage;
  int error_cnt = 0;
  int compares = 0;
  assign romData = 8'(cfgIdx - 8'h01) ^ 8'hA5;
  assign otpValid = otpRd && cfgIdx == 8'h11;
  assign otpData = 8'h77;
  hub_boot_config_sequencer #(.PLL_LOCK(16'h0004)) hub_boot_config_sequencer_i (.*);
  hbc_far_model hbc_far_model_i (.*);
  initial forever #12.5 ref_clk = ~ref_clk;
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_st(input logic [3:0] s, input int lim);
    int n;
    n = 0;
    while (bootStage !== s && n < lim) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(24'(bootStage), 24'(s));
    if (bootStage !== s)
      wrap_up();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 chk(24'(regRdData), 24'(exp));
  endtask
  task automatic boot(input logic [2:0] bs, input logic pu, bad, input logic [1:0] m, input logic [3:0] d);
    rstn <= 1'b0;
    bootSelectStraps <= bs;
    sdaPullup <= pu;
    sclPullup <= pu;
    badSig <= bad;
    endMode <= m;
    ackDly <= d;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
  endtask
  initial begin
    boot(3'h0, 1'b0, 1'b0, 2'h0, 4'h5);
    wait_st(4'h2, 200);
    chk(24'(execFromFlash), 24'h1);
    chk(24'(pllRun), 24'h1);
    chk(24'({flashWidth, flashMode3}), 24'h2);
    $display("test flash boot end");
    boot(3'h0, 1'b0, 1'b1, 2'h0, 4'h0);
    wait_st(4'h3, 200);
    wait_st(4'h7, 300);
    wait_st(4'h8, 300);
    @(posedge ref_clk);
    #1 chk({portDisP, portDisM, nonRemovable, chargeEn, usb2AttachBit, superspeedHubEnableBit, portsEnable,
      dataPinsDrive}, {6'h2A, 6'h15, 6'h2F});
    hostStarted <= 1'b1;
    wait_st(4'h9, 5);
    softDisconnect <= 1'b1;
    wait_st(4'h8, 5);
    repeat (4) @(posedge ref_clk);
    #1 chk({usb2AttachBit, bootStage}, 24'h08);
    softDisconnect <= 1'b0;
    wait_st(4'h9, 5);
    rstn <= 1'b0;
    #1 chk({bootStage, portDisP, pllRun, portsEnable, dataPinsDrive}, 24'h0);
    hostStarted <= 1'b0;
    $display("test rom path end");
    for (int m = 0; m < 3; m++) begin
      boot(3'h1, 1'b1, 1'b0, 2'(m), 4'h0);
      wait_st(4'h6, 400);
      wait_st(4'h8, 900);
      chk(24'(keepSideband), (m == 2) ? 24'h1 : 24'h0);
      rd(8'h10, 8'h77);
      rd(8'h20, 8'h3C);
      rd(8'hFF, 8'h5A);
      $display("test sideband mode %0d end", m);
    end
    boot(3'h1, 1'b0, 1'b0, 2'h1, 4'h0);
    wait_st(4'h8, 900);
    chk(24'(sidebandSlave), 24'h0);
    $display("test no pullup end");
    wrap_up();
  end
endmodule // testbench
